// ===== hw/instr_exec_core.sv
// Purpose: Executes return, rotate through carry, sleep and literal-minus-accumulator ops
// Assumes: APB master on ref_clk, one-cycle-per-instruction timing except the two-cycle return, at 125 MHz
// Notes: Ops are launched by writing the control register; the return op keeps the core busy
//        Popping an empty stack wraps the pointer; software must push before a return
//
// What this block does
// - Return pops stack, loads popped top entry into PC, takes two cycles.
// - Rotate left: bit n to n+1, bit 7 to carry, carry to bit 0.
// - Rotate destination select 0 writes accumulator, 1 writes file register back.
// - Rotate right: bit n to n-1, bit 0 to carry, carry to bit 7.
// - Sleep clears watchdog counter and its prescaler.
// - Sleep clears power-down flag, sets time-out flag, leaves other status alone.
// - Literal minus accumulator into accumulator; carry 0 only when accumulator exceeds literal.
// - Nibble carry 0 when accumulator low nibble exceeds literal low nibble, else 1.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "instr_exec_regs.svh"

module instr_exec_core
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [`IX_PC_W-1:0] pc,
   output logic [7:0] acc,
   output logic sleep_pulse
);

   instr_exec_pkg::core_state_t s_q;
   instr_exec_pkg::core_state_t s_d;

   // Address decode shared by the read and write paths
   function automatic logic addr_hit(input logic [7:0] a);
      addr_hit = (a == `IX_CTRL_OFS) || (a == `IX_ACC_OFS) || (a == `IX_FILE_OFS) ||
                 (a == `IX_STATUS_OFS) || (a == `IX_STACK_OFS) || (a == `IX_PC_OFS) ||
                 (a == `IX_WDOG_OFS) || (a == `IX_DEPTH_OFS);
   endfunction

   logic access;
   logic busy;
   logic ctrl_go;
   logic [2:0] op;
   logic dest_sel;
   logic [7:0] lit;
   logic [7:0] rotl_val;
   logic [7:0] rotr_val;
   logic [8:0] sub_full;
   logic [7:0] sub_val;
   logic sub_nib;
   logic [`IX_PC_W-1:0] top_entry;

   // Access phase is answered one cycle late, so pready can come from a flop
   assign access = psel && penable && !s_q.pready;
   assign busy = (s_q.st != instr_exec_pkg::ST_IDLE);
   assign op = pwdata[`IX_OP_MSB:`IX_OP_LSB];
   assign dest_sel = pwdata[`IX_DEST_BIT];
   assign lit = pwdata[`IX_LIT_MSB:`IX_LIT_LSB];
   // Ops written while a return is in flight are dropped, not queued
   assign ctrl_go = access && pwrite && (paddr == `IX_CTRL_OFS) && !busy;
   assign top_entry = s_q.stack[s_q.sp - 4'h1];

   // Datapath results
   assign rotl_val = {s_q.file[6:0], s_q.carry};
   assign rotr_val = {s_q.carry, s_q.file[7:1]};
   assign sub_full = {1'b0, lit} - {1'b0, s_q.acc};
   assign sub_val = sub_full[7:0];
   assign sub_nib = (s_q.acc[3:0] <= lit[3:0]);

   // Next-state logic
   always_comb
   begin
      s_d = s_q;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      s_d.sleep_pulse = 1'b0;
      // Watchdog runs free; counter steps on prescaler wrap
      s_d.presc = s_q.presc + 8'h01;
      if (s_q.presc == 8'hFF)
      begin
         s_d.wdog = s_q.wdog + 8'h01;
      end
      // Return sequencer: pop in first cycle, load PC in second
      unique case (s_q.st)
         instr_exec_pkg::ST_IDLE:
         begin
            s_d.st = s_q.st;
         end
         instr_exec_pkg::ST_RET_POP:
         begin
            s_d.ret_addr = top_entry;
            s_d.sp = s_q.sp - 4'h1;
            s_d.st = instr_exec_pkg::ST_RET_LOAD;
         end
         instr_exec_pkg::ST_RET_LOAD:
         begin
            s_d.pc = s_q.ret_addr;
            s_d.st = instr_exec_pkg::ST_IDLE;
         end
         // A corrupted state code falls back to idle rather than locking the core busy
         default:
         begin
            s_d.st = instr_exec_pkg::ST_IDLE;
         end
      endcase
      // APB slave
      if (access)
      begin
         s_d.pready = 1'b1;
         s_d.prdata = 32'h0000_0000;
         if (!addr_hit(paddr))
         begin
            s_d.pslverr = 1'b1;
         end
         else if (pwrite)
         begin
            unique case (paddr)
               `IX_CTRL_OFS:
               begin
                  if (ctrl_go)
                  begin
                     unique case (op)
                        `IX_OP_RETURN:
                        begin
                           s_d.st = instr_exec_pkg::ST_RET_POP;
                        end
                        `IX_OP_ROTL, `IX_OP_ROTR:
                        begin
                           // Only carry changes among the flags
                           s_d.carry = (op == `IX_OP_ROTL) ? s_q.file[7] : s_q.file[0];
                           if (dest_sel)
                           begin
                              s_d.file = (op == `IX_OP_ROTL) ? rotl_val : rotr_val;
                           end
                           else
                           begin
                              s_d.acc = (op == `IX_OP_ROTL) ? rotl_val : rotr_val;
                           end
                        end
                        `IX_OP_SLEEP:
                        begin
                           s_d.wdog = `IX_WDOG_ZERO;
                           s_d.presc = `IX_WDOG_ZERO;
                           s_d.power_down_flag = 1'b0;
                           s_d.time_out_flag = 1'b1;
                           s_d.sleep_pulse = 1'b1;
                        end
                        `IX_OP_SUBLIT:
                        begin
                           s_d.acc = sub_val;
                           s_d.carry = !sub_full[8];
                           s_d.nib = sub_nib;
                           s_d.zero = (sub_val == 8'h00);
                        end
                        default:
                        begin
                           s_d.st = s_q.st;
                        end
                     endcase
                  end
               end
               `IX_ACC_OFS: s_d.acc = pwdata[7:0];
               `IX_FILE_OFS: s_d.file = pwdata[7:0];
               `IX_STATUS_OFS:
               begin
                  s_d.carry = pwdata[`IX_ST_CARRY];
                  s_d.nib = pwdata[`IX_ST_NIB];
                  s_d.zero = pwdata[`IX_ST_ZERO];
                  s_d.power_down_flag = pwdata[`IX_ST_POWER_DOWN];
                  s_d.time_out_flag = pwdata[`IX_ST_TIME_OUT];
               end
               `IX_STACK_OFS:
               begin
                  // Push is held off during a return so the pop sees a steady stack
                  if (!busy)
                  begin
                     s_d.stack[s_q.sp] = pwdata[`IX_PC_W-1:0];
                     s_d.sp = s_q.sp + 4'h1;
                  end
               end
               `IX_PC_OFS:
               begin
                  if (!busy)
                  begin
                     s_d.pc = pwdata[`IX_PC_W-1:0];
                  end
               end
               default:
               begin
                  s_d.prdata = 32'h0000_0000;
               end
            endcase
         end
         else
         begin
            unique case (paddr)
               `IX_CTRL_OFS: s_d.prdata = {29'h0000_0000, s_q.st};
               `IX_ACC_OFS: s_d.prdata = {24'h00_0000, s_q.acc};
               `IX_FILE_OFS: s_d.prdata = {24'h00_0000, s_q.file};
               `IX_STATUS_OFS: s_d.prdata = {26'h000_0000, busy, s_q.time_out_flag, s_q.power_down_flag,
                  s_q.zero, s_q.nib, s_q.carry};
               `IX_STACK_OFS: s_d.prdata = {17'h0_0000, top_entry};
               `IX_PC_OFS: s_d.prdata = {17'h0_0000, s_q.pc};
               `IX_WDOG_OFS: s_d.prdata = {16'h0000, s_q.presc, s_q.wdog};
               `IX_DEPTH_OFS: s_d.prdata = {28'h000_0000, s_q.sp};
               default: s_d.prdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // State register, synchronous active-low reset
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         s_q <= '0;
         s_q.st <= instr_exec_pkg::ST_IDLE;
         s_q.power_down_flag <= `IX_POWER_DOWN_RST;
         s_q.time_out_flag <= `IX_TIME_OUT_RST;
         s_q.pc <= `IX_PC_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state flops
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign pc = s_q.pc;
   assign acc = s_q.acc;
   assign sleep_pulse = s_q.sleep_pulse;

   // Launch qualifiers for the checks
   logic ret_go;
   logic rotl_go;
   logic rotr_go;
   logic sleep_go;
   logic sub_go;
   assign ret_go = ctrl_go && (op == `IX_OP_RETURN);
   assign rotl_go = ctrl_go && (op == `IX_OP_ROTL);
   assign rotr_go = ctrl_go && (op == `IX_OP_ROTR);
   assign sleep_go = ctrl_go && (op == `IX_OP_SLEEP);
   assign sub_go = ctrl_go && (op == `IX_OP_SUBLIT);

   // Checks run on the core clock and stay quiet through reset
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence ret_steps;
      (s_q.st == instr_exec_pkg::ST_RET_POP) ##1 (s_q.st == instr_exec_pkg::ST_RET_LOAD) ##1
      (s_q.st == instr_exec_pkg::ST_IDLE);
   endsequence

   chk_return_pc_load: assert property (ret_go |=> ret_steps ##0 (s_q.pc == $past(top_entry, 3)))
      else $error("return did not load popped entry after two cycles");
   chk_return_pop: assert property (ret_go |-> ##2 (s_q.sp == $past(s_q.sp, 2) - 4'h1))
      else $error("return did not pop the stack");
   chk_rotl_result: assert property (rotl_go && !dest_sel |=> (s_q.acc == $past(rotl_val)) &&
      (s_q.carry == $past(s_q.file[7])) && $stable(s_q.zero) && $stable(s_q.nib))
      else $error("left rotate result or carry wrong");
   chk_rot_dest_file: assert property ((rotl_go || rotr_go) && dest_sel |=> $stable(s_q.acc) &&
      (s_q.file == ($past(rotl_go) ? $past(rotl_val) : $past(rotr_val))))
      else $error("rotate with file destination went astray");
   chk_rotr_result: assert property (rotr_go && !dest_sel |=> (s_q.acc == $past(rotr_val)) &&
      (s_q.carry == $past(s_q.file[0])) && $stable(s_q.file))
      else $error("right rotate result or carry wrong");
   chk_sleep_wdog: assert property (sleep_go |=> (s_q.wdog == 8'h00) && (s_q.presc == 8'h00))
      else $error("sleep did not clear watchdog");
   chk_sleep_flags: assert property (sleep_go |=> !s_q.power_down_flag && s_q.time_out_flag &&
      sleep_pulse && $stable(s_q.carry) && $stable(s_q.zero) && $stable(s_q.nib))
      else $error("sleep status flags wrong");
   chk_sub_carry: assert property (sub_go |=> (s_q.acc == $past(sub_val)) &&
      (s_q.carry == ($past(s_q.acc) <= $past(lit))))
      else $error("literal minus accumulator result or carry wrong");
   chk_sub_nibble: assert property (sub_go |=> s_q.nib == ($past(s_q.acc[3:0]) <= $past(lit[3:0])))
      else $error("nibble carry wrong");
   chk_sub_zero: assert property (sub_go |=> s_q.zero == (s_q.acc == 8'h00))
      else $error("zero flag wrong");

   // Rotates may only move carry among the flags
   chk_rot_flags_keep: assert property ((rotl_go || rotr_go) |=>
      $stable(s_q.zero) && $stable(s_q.nib) && $stable(s_q.power_down_flag) && $stable(s_q.time_out_flag))
      else $error("rotate touched a flag other than carry");
   // Return holds the core busy for exactly two cycles
   chk_return_two_cycles: assert property (ret_go |=> busy [*2] ##1 !busy)
      else $error("return did not take two cycles");
   // Subtraction result goes to the accumulator only
   chk_sub_keep: assert property (sub_go |=> $stable(s_q.file) && $stable(s_q.power_down_flag) &&
      $stable(s_q.time_out_flag))
      else $error("literal minus accumulator touched other state");
   // Unmapped addresses answer with an error and change nothing
   chk_refused_access: assert property (access && !addr_hit(paddr) |=> pready && pslverr && $stable(s_q.acc) &&
      $stable(s_q.file))
      else $error("unmapped access was not refused cleanly");

endmodule

// ===== inc/instr_exec_regs.svh
// Purpose: Offsets, field positions, reset values and counts for the instruction execution block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef INSTR_EXEC_REGS_SVH
`define INSTR_EXEC_REGS_SVH

// Register byte offsets
`define IX_CTRL_OFS 8'h00
`define IX_ACC_OFS 8'h04
`define IX_FILE_OFS 8'h08
`define IX_STATUS_OFS 8'h0C
`define IX_STACK_OFS 8'h10
`define IX_PC_OFS 8'h14
`define IX_WDOG_OFS 8'h18
`define IX_DEPTH_OFS 8'h1C

// Control word fields
`define IX_OP_MSB 2
`define IX_OP_LSB 0
`define IX_DEST_BIT 3
`define IX_LIT_MSB 15
`define IX_LIT_LSB 8

// Op codes
`define IX_OP_NONE 3'h0
`define IX_OP_RETURN 3'h1
`define IX_OP_ROTL 3'h2
`define IX_OP_ROTR 3'h3
`define IX_OP_SLEEP 3'h4
`define IX_OP_SUBLIT 3'h5

// Status bit positions
`define IX_ST_CARRY 0
`define IX_ST_NIB 1
`define IX_ST_ZERO 2
`define IX_ST_POWER_DOWN 3
`define IX_ST_TIME_OUT 4
`define IX_ST_BUSY 5

// Widths and sizes
`define IX_PC_W 15
`define IX_STACK_DEPTH 16
`define IX_SP_W 4

// Reset values
`define IX_POWER_DOWN_RST 1'b1
`define IX_TIME_OUT_RST 1'b1
`define IX_PC_RST 15'h0000
`define IX_WDOG_ZERO 8'h00

// Cycles that a subroutine return occupies
`define IX_RETURN_CYCLES 2

`endif

// ===== inc/instr_exec_pkg.sv
// Purpose: Types for the instruction execution block
// Assumes: Constants come from the register header
// Notes: Types only
`include "instr_exec_regs.svh"

package instr_exec_pkg;

   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_RET_POP = 3'h2,
      ST_RET_LOAD = 3'h4
   } exec_state_t;

   // Whole state of the execution core
   typedef struct packed {
      exec_state_t st;
      logic [7:0] acc;
      logic [7:0] file;
      logic carry;
      logic nib;
      logic zero;
      logic power_down_flag;
      logic time_out_flag;
      logic [`IX_PC_W-1:0] pc;
      logic [`IX_PC_W-1:0] ret_addr;
      logic [`IX_SP_W-1:0] sp;
      logic [`IX_STACK_DEPTH-1:0][`IX_PC_W-1:0] stack;
      logic [7:0] wdog;
      logic [7:0] presc;
      logic sleep_pulse;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } core_state_t;

endpackage

// ===== sim/tb.sv
// Purpose: Self-checking bench for the instruction execution core over APB
// Assumes: Core answers every transfer with pready; waits are bounded anyway
// Notes: Only mismatches and the verdict are printed
`timescale 1ns/100ps
`include "instr_exec_regs.svh"

module tb;
   logic ref_clk;
   logic rstn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [`IX_PC_W-1:0] pc;
   logic [7:0] acc;
   logic sleep_pulse;
   int fail_count = 0;
   int cmp_count = 0;
   int pulses = 0;
   logic [7:0] kv [5] = '{8'hFF, 8'h05, 8'h03, 8'h15, 8'h10};
   logic [7:0] wv [5] = '{8'h00, 8'h05, 8'h05, 8'h07, 8'h0F};

   instr_exec_core uut
   (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .pc(pc),
      .acc(acc),
      .sleep_pulse(sleep_pulse)
   );

   // Clock at 125 MHz
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // Count sleep pulses; a stuck pulse shows up as too many
   always @(posedge ref_clk)
   begin
      if (sleep_pulse === 1'b1)
         pulses <= pulses + 1;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic end_sim;
      if (fail_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // One APB transfer; request held until pready is seen at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         fail_count++;
         end_sim();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic e;
      xfer(1'b1, a, d, rd, e);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic e;
      xfer(1'b0, a, 32'h00000000, rd, e);
      chk(rd, exp);
   endtask

   // Rotate through carry with both destinations; other flags must survive
   task automatic rot(input logic [2:0] op, input logic d, input logic [7:0] f, input logic c);
      logic [7:0] r;
      logic nc;
      r = (op == `IX_OP_ROTL) ? {f[6:0], c} : {c, f[7:1]};
      nc = (op == `IX_OP_ROTL) ? f[7] : f[0];
      wr(`IX_FILE_OFS, {24'h000000, f});
      wr(`IX_ACC_OFS, 32'h0000005A);
      wr(`IX_STATUS_OFS, {27'h0000000, 4'hA, c});
      wr(`IX_CTRL_OFS, {28'h0000000, d, op});
      rd_chk(`IX_FILE_OFS, {24'h000000, d ? r : f});
      rd_chk(`IX_ACC_OFS, {24'h000000, d ? 8'h5A : r});
      rd_chk(`IX_STATUS_OFS, {27'h0000000, 4'hA, nc});
   endtask

   // Main sequence
   initial
   begin
      logic [31:0] rd;
      logic e;
      logic [7:0] r;
      int p0;
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      rd_chk(`IX_STATUS_OFS, 32'h00000018);
      rd_chk(`IX_DEPTH_OFS, 32'h00000000);
      xfer(1'b0, 8'h20, 32'h00000000, rd, e);
      chk({31'h00000000, e}, 32'h00000001);
      for (int i = 0; i < 8; i++)
         rot(i[2] ? `IX_OP_ROTR : `IX_OP_ROTL, i[1], i[0] ? 8'hE6 : 8'h67, i[0] ^ i[2]);
      // Subtraction corners: zero, borrow, nibble borrow only, extremes
      for (int i = 0; i < 5; i++)
      begin
         r = kv[i] - wv[i];
         wr(`IX_ACC_OFS, {24'h000000, wv[i]});
         wr(`IX_STATUS_OFS, 32'h00000018);
         wr(`IX_CTRL_OFS, {16'h0000, kv[i], 5'h00, `IX_OP_SUBLIT});
         rd_chk(`IX_ACC_OFS, {24'h000000, r});
         chk({24'h000000, acc}, {24'h000000, r});
         rd_chk(`IX_STATUS_OFS, {27'h0000000, 2'b11, r == 8'h00, wv[i][3:0] <= kv[i][3:0], wv[i] <= kv[i]});
      end
      // Two returns, separated by reads of PC and depth, unwind the stack in order
      wr(`IX_STACK_OFS, 32'h00001234);
      wr(`IX_STACK_OFS, 32'h00000ABC);
      wr(`IX_CTRL_OFS, {29'h00000000, `IX_OP_RETURN});
      chk({17'h00000, pc}, 32'h00000000);
      rd_chk(`IX_PC_OFS, 32'h00000ABC);
      rd_chk(`IX_DEPTH_OFS, 32'h00000001);
      wr(`IX_CTRL_OFS, {29'h00000000, `IX_OP_RETURN});
      rd_chk(`IX_PC_OFS, 32'h00001234);
      chk({17'h00000, pc}, 32'h00001234);
      // Op code 0 does nothing; state, stack top and program counter read back
      wr(`IX_CTRL_OFS, 32'h00000000);
      rd_chk(`IX_CTRL_OFS, 32'h00000001);
      chk({24'h000000, acc}, 32'h00000001);
      wr(`IX_STACK_OFS, 32'h00007FFF);
      rd_chk(`IX_STACK_OFS, 32'h00007FFF);
      wr(`IX_PC_OFS, 32'h00000155);
      rd_chk(`IX_PC_OFS, 32'h00000155);
      chk({17'h00000, pc}, 32'h00000155);
      // Sleep after the watchdog has advanced
      wr(`IX_STATUS_OFS, 32'h0000000D);
      repeat (600) @(posedge ref_clk);
      xfer(1'b0, `IX_WDOG_OFS, 32'h00000000, rd, e);
      chk(32'(rd[7:0] != 8'h00), 32'h00000001);
      p0 = pulses;
      wr(`IX_CTRL_OFS, {29'h00000000, `IX_OP_SLEEP});
      xfer(1'b0, `IX_WDOG_OFS, 32'h00000000, rd, e);
      chk({24'h000000, rd[7:0]}, 32'h00000000);
      chk(32'(rd[15:8] < 8'h10), 32'h00000001);
      rd_chk(`IX_STATUS_OFS, 32'h00000015);
      chk(32'(pulses - p0), 32'h00000001);
      end_sim();
   end
endmodule
